// ===== verilog/cmx_input_select.sv
// comparator1 input select register and analog switch decode
//
// Behaviour
// RL1: 8-bit RW register, page 0x0 address 0x9E
// RL2: reset loads all ones
// RL3: bits 7:4 pick negative input source
// RL4: bits 3:0 pick positive input source
// RL5: code 1100 selects touch sense reference
// RL6: code 1101 selects half MCU supply
// RL7: divider enabled only when half selected
// RL8: one-hot selects; reserved codes open all
`timescale 1ns/1ps
`include "cmx_defs.svh"

module cmx_input_select (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_page_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    output logic [15:0] neg_sel_o,
    output logic [15:0] pos_sel_o,
    output logic half_div_en_o
);

    // ------------------------------------------------------------
    // register
    // ------------------------------------------------------------
    logic [7:0] comparator1_input_select;
    logic hit;
    cmx_pkg::cmx_code_t negative_input_code;
    cmx_pkg::cmx_code_t positive_input_code;
    cmx_pkg::cmx_code_t next_neg;
    cmx_pkg::cmx_code_t next_pos;
    cmx_pkg::cmx_onehot_t next_neg_sel;
    cmx_pkg::cmx_onehot_t next_pos_sel;

    assign hit = (sfr_addr_i == `CMX_SEL_ADDR) &&
                 (sfr_page_i == `CMX_SFR_PAGE);

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            comparator1_input_select <= `CMX_SEL_RESET; // RL2
        else if (sfr_wr_i && hit)
            comparator1_input_select <= sfr_wdata_i; // RL1
    end

    // read data registered; other addresses return zero
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            sfr_rdata_o <= 8'h00;
        else if (sfr_rd_i && hit)
            sfr_rdata_o <= comparator1_input_select; // RL1
        else
            sfr_rdata_o <= 8'h00;
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign negative_input_code =
        comparator1_input_select[`CMX_NEG_MSB:`CMX_NEG_LSB]; // RL3
    assign positive_input_code =
        comparator1_input_select[`CMX_POS_MSB:`CMX_POS_LSB]; // RL4

    // decode from the next register value so selects stay in step
    always_comb
    begin
        next_neg = negative_input_code;
        next_pos = positive_input_code;
        if (sfr_wr_i && hit)
        begin
            next_neg = sfr_wdata_i[`CMX_NEG_MSB:`CMX_NEG_LSB];
            next_pos = sfr_wdata_i[`CMX_POS_MSB:`CMX_POS_LSB];
        end
    end

    // the two inputs differ only in which of codes 6 and 11 is reserved
    cmx_code_decode #(
        .IS_NEG(1'b1)
    ) neg_decode_i (
        .code_i(next_neg),
        .sel_o(next_neg_sel)
    ); // RL3 RL5 RL6 RL8

    cmx_code_decode #(
        .IS_NEG(1'b0)
    ) pos_decode_i (
        .code_i(next_pos),
        .sel_o(next_pos_sel)
    ); // RL4 RL5 RL6 RL8

    // bit n of a select closes the switch for code n; bit 12 is the
    // touch reference, bit 13 the half supply
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            neg_sel_o <= 16'h8000;
            pos_sel_o <= 16'h8000;
        end
        else
        begin
            neg_sel_o <= next_neg_sel; // RL3 RL5 RL6 RL8
            pos_sel_o <= next_pos_sel; // RL4 RL5 RL6 RL8
        end
    end

    // divider draws current only while some input uses it
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            half_div_en_o <= 1'b0;
        else
            half_div_en_o <= (next_neg == `CMX_CODE_HALF) ||
                             (next_pos == `CMX_CODE_HALF); // RL7
    end

endmodule : cmx_input_select

// ------------------------------------------------------------
// code to switch select decode, one per comparator input
// ------------------------------------------------------------
module cmx_code_decode #(
    parameter bit IS_NEG = 1'b0
) (
    input wire logic [3:0] code_i,
    output logic [15:0] sel_o
);

    logic [15:0] raw_sel;
    logic usable;

    // table written out so each source can be audited against its code
    always_comb
    begin
        raw_sel = 16'h0000;
        usable = 1'b0;
        case (code_i)
            4'h0:
            begin
                raw_sel = 16'h0001;
                usable = 1'b1;
            end
            4'h1:
            begin
                raw_sel = 16'h0002;
                usable = 1'b1;
            end
            4'h2:
            begin
                raw_sel = 16'h0004;
                usable = 1'b1;
            end
            4'h3:
            begin
                raw_sel = 16'h0008;
                usable = 1'b1;
            end
            4'h4:
            begin
                raw_sel = 16'h0010;
                usable = 1'b0; // RL8
            end
            4'h5:
            begin
                raw_sel = 16'h0020;
                usable = 1'b0; // RL8
            end
            4'h6:
            begin
                raw_sel = 16'h0040;
                usable = IS_NEG; // RL8
            end
            4'h7:
            begin
                raw_sel = 16'h0080;
                usable = 1'b1;
            end
            4'h8:
            begin
                raw_sel = 16'h0100;
                usable = 1'b1;
            end
            4'h9:
            begin
                raw_sel = 16'h0200;
                usable = 1'b1;
            end
            4'hA:
            begin
                raw_sel = 16'h0400;
                usable = 1'b1;
            end
            4'hB:
            begin
                raw_sel = 16'h0800;
                usable = !IS_NEG; // RL8
            end
            4'hC:
            begin
                raw_sel = 16'h1000;
                usable = 1'b1; // RL5
            end
            4'hD:
            begin
                raw_sel = 16'h2000;
                usable = 1'b1; // RL6
            end
            4'hE:
            begin
                raw_sel = 16'h4000;
                usable = 1'b1;
            end
            4'hF:
            begin
                raw_sel = 16'h8000;
                usable = 1'b1;
            end
            default:
            begin
                raw_sel = 16'h0000;
                usable = 1'b0;
            end
        endcase
    end

    // reserved codes leave every switch of this input open
    assign sel_o = usable ? raw_sel : 16'h0000; // RL8

endmodule : cmx_code_decode

// ===== verilog/cmx_defs.svh
// constants for the comparator1 input select block
`ifndef CMX_DEFS_SVH
`define CMX_DEFS_SVH

`define CMX_SFR_PAGE 8'h00
`define CMX_SEL_ADDR 8'h9E
`define CMX_SEL_RESET 8'hFF
`define CMX_NEG_MSB 7
`define CMX_NEG_LSB 4
`define CMX_POS_MSB 3
`define CMX_POS_LSB 0
`define CMX_CODE_TOUCH 4'hC
`define CMX_CODE_HALF 4'hD
`define CMX_CODE_SUPPLY 4'hE
`define CMX_CODE_TOP 4'hF

`endif

// ===== verilog/cmx_pkg.sv
// types for the comparator1 input select block
package cmx_pkg;
    typedef logic [3:0] cmx_code_t;
    typedef logic [15:0] cmx_onehot_t;
endpackage : cmx_pkg

// ===== tb/cmx_monitor.sv
// assertion checker for the comparator1 input select ports
`timescale 1ns/1ps
module cmx_monitor(input wire logic clk_i,rst_i,sfr_wr_i,sfr_rd_i,
input wire logic [7:0] sfr_addr_i,sfr_page_i,sfr_wdata_i,sfr_rdata_o,
input wire logic [15:0] neg_sel_o,pos_sel_o,
input wire logic half_div_en_o);
default clocking @(posedge clk_i);endclocking
default disable iff(rst_i);
wire logic h=sfr_addr_i==8'h9E&&sfr_page_i==8'h00;
wire logic w=sfr_wr_i&&h;
wire logic [7:0] d=sfr_wdata_i;
property p_rd;!(sfr_rd_i&&h)|=>sfr_rdata_o==8'h00;endproperty
a_rd:assert property(p_rd)else $error("stray rdata");
property p_rst;$fell(rst_i)|->neg_sel_o==16'h8000&&pos_sel_o==16'h8000;
endproperty
a_rst:assert property(p_rst)else $error("reset sel");
property p_neg;w&&d[7:4]==4'hF|=>neg_sel_o==16'h8000;endproperty
a_neg:assert property(p_neg)else $error("neg sel");
property p_pos;w&&d[3:0]==4'h0|=>pos_sel_o==16'h0001;endproperty
a_pos:assert property(p_pos)else $error("pos sel");
property p_tch;w&&d[3:0]==4'hC|=>pos_sel_o==16'h1000;endproperty
a_tch:assert property(p_tch)else $error("touch sel");
property p_half;w&&d[7:4]==4'hD|=>neg_sel_o[13]&&half_div_en_o;endproperty
a_half:assert property(p_half)else $error("half sel");
property p_div;half_div_en_o==(neg_sel_o[13]||pos_sel_o[13]);endproperty
a_div:assert property(p_div)else $error("divider");
property p_res;w&&d[7:4]==4'hB|=>neg_sel_o==16'h0000;endproperty
a_res:assert property(p_res)else $error("reserved");
endmodule:cmx_monitor

// ===== tb/cmx_input_select_tb_top.sv
// self-checking bench for the comparator1 input select block
`timescale 1ns/1ps
module cmx_input_select_tb_top;
logic clk_i=0,rst_i=1,sfr_wr_i=0,sfr_rd_i=0,half_div_en_o;
logic [7:0] sfr_addr_i=8'h9E,sfr_page_i=8'h00,sfr_wdata_i=8'h00;
logic [7:0] sfr_rdata_o,m,a,p,v;
logic [15:0] neg_sel_o,pos_sel_o;
logic [31:0] r=68097;
int error_cnt=0,num_checks=0;
always #2.5 clk_i=~clk_i;
cmx_input_select cmx_input_select_i(.*);
function logic [31:0] nx(logic [31:0] x);
return {x[30:0],x[31]^x[21]^x[1]^x[0]};endfunction:nx
function logic [15:0] es(logic [3:0] c,bit n);
return (c==4||c==5||c==(n?11:6))?16'h0:16'h1<<c;endfunction:es
task chk(string n,logic [15:0] e,g);num_checks++;
if(g!==e)begin error_cnt++;
$display("wrong value %s exp %h got %h",n,e,g);end endtask:chk
task acc(logic w,logic [7:0] ad,pg,dt);@(negedge clk_i);sfr_wr_i=w;
sfr_rd_i=!w;sfr_addr_i=ad;sfr_page_i=pg;sfr_wdata_i=dt;
@(negedge clk_i);sfr_wr_i=0;sfr_rd_i=0;endtask:acc
task print_verdict;$display("errors %0d checks %0d",error_cnt,num_checks);
if(error_cnt==0&&num_checks>0)$display("All tests passed");
else $display("Some tests failed");
$finish;endtask:print_verdict
initial begin m=8'hFF;repeat(12)@(posedge clk_i);
@(negedge clk_i)rst_i=0;
acc(0,8'h9E,0,0);chk("rdata",8'hFF,sfr_rdata_o);
for(int i=0;i<600;i++)begin r=nx(r);
a=(i<256||r[9:8]!=0)?8'h9E:r[31:24];p={7'h0,i>255&&r[12:10]==0};
v=i<256?i[7:0]:r[7:0];acc(1,a,p,v);if(a==8'h9E&&p==0)m=v;
chk("neg",es(m[7:4],1),neg_sel_o);
chk("pos",es(m[3:0],0),pos_sel_o);
chk("half",m[7:4]==4'hD||m[3:0]==4'hD,half_div_en_o);
acc(0,a,p,0);chk("rdata",a==8'h9E&&p==0?m:0,sfr_rdata_o);
end
@(negedge clk_i)rst_i=1;@(negedge clk_i);
chk("neg",16'h8000,neg_sel_o);
chk("pos",16'h8000,pos_sel_o);
chk("half",0,half_div_en_o);
@(negedge clk_i)rst_i=0;m=8'hFF;
acc(0,8'h9E,0,0);chk("rdata",8'hFF,sfr_rdata_o);
print_verdict;end
endmodule:cmx_input_select_tb_top
bind cmx_input_select cmx_monitor cmx_monitor_i(.*);
